// File: hdl/tfrc_ctrl.sv
`default_nettype none
`include "tfrc_consts.svh"
// Overview of operation
// RQ1: byte command 0x50 holds overtemp response, resets to 0xB8.
// RQ2: byte command 0x54 holds undertemp response, resets to 0xB8.
// RQ3: overtemp fault sets temperature summary bit, overtemp status bit, alert.
// RQ4: undertemp fault sets temperature summary bit, undertemp status bit, alert.
// RQ5: faults come from ADC samples; response within 80 ms allowed.
// RQ6: response 00 keeps output running but still flags and alerts.
// RQ7: writing response 01 or 11 raises a communication fault.
// RQ8: response 10 disables output at once, then follows retry field.
// RQ9: fault bits clear only by clear command, off-on cycle or power loss.
// RQ10: retry 000 never restarts; output stays off until cleared or off.
// RQ11: retry 111 restarts repeatedly after the retry interval until off.
// RQ12: delay field bits 2:0 are ignored.
// RQ13: word command 0xD2 holds pin mask, resets to 0x2993.
// RQ14: only faults that cause a response may reach the pin.
// RQ15: mask bit 7 pulls pin low while overtemp fault present.
// RQ16: mask bit 8 pulls pin low while undertemp fault present.
// RQ17: default response decodes as shutdown with endless retry.
module tfrc_ctrl #(
  parameter int unsigned RETRY_CYCLES = `TFRC_RETRY_CYCLES
) (
  input  wire logic              clk_in,         // device clock, 200 MHz
  input  wire logic              rst_b_in,       // async reset, active low
  input  wire tfrc_pkg::tfrc_cmd_t cmd_in,       // decoded bus command
  input  wire tfrc_pkg::tfrc_fault_t fault_in,   // ADC fault levels
  input  wire logic              clear_faults_in,// clear command pulse
  input  wire logic              on_cmd_in,      // run pin and operation on
  output logic [15:0]            rd_data_out,    // read answer
  output logic                   rd_valid_out,   // read answer valid pulse
  output logic                   cml_fault_out,  // bad write flagged
  output logic                   temp_summary_out,// temperature summary bit
  output logic                   ot_status_out,  // latched overtemp bit
  output logic                   ut_status_out,  // latched undertemp bit
  output logic                   alert_b_out,    // alert, active low
  output logic                   gpio_b_out,     // gpio drive, active low
  output logic                   output_en_out   // regulator enable
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  ot_resp;
  logic [7:0]  ut_resp;
  logic [15:0] pin_mask;
  logic        on_q;
  logic        off_on_clear;
  logic        ot_event;
  logic        ut_event;
  logic        ot_q;
  logic        ut_q;
  logic        wr_resp;
  logic        bad_act;
  logic        ot_shut;
  logic        ut_shut;
  logic        any_shut;
  logic        forever_retry;
  logic        retry_done;
  logic        retry_start;
  tfrc_pkg::tfrc_state_t state;
  tfrc_pkg::tfrc_state_t next_state;

  assign wr_resp = cmd_in.wr && (cmd_in.code == `TFRC_CMD_OT_RESP || cmd_in.code == `TFRC_CMD_UT_RESP);
  assign bad_act = cmd_in.data[`TFRC_RESP_LO] != 1'b0; // 01 and 11 both have low bit set [RQ7]
  ////////////////////////////////////////////////////////////////////////
  // delay field is stored for readback only, nothing uses it [RQ12]
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ot_resp  <= `TFRC_RESP_RESET; // [RQ1] [RQ17]
      ut_resp  <= `TFRC_RESP_RESET; // [RQ2]
      pin_mask <= `TFRC_MASK_RESET; // [RQ13]
    end
    else if (cmd_in.wr)
    begin
      // unsupported actions are refused so the stored byte stays legal
      if (cmd_in.code == `TFRC_CMD_OT_RESP && !bad_act)
        ot_resp <= cmd_in.data[7:0]; // [RQ1]
      if (cmd_in.code == `TFRC_CMD_UT_RESP && !bad_act)
        ut_resp <= cmd_in.data[7:0]; // [RQ2]
      if (cmd_in.code == `TFRC_CMD_PIN_MASK)
        pin_mask <= cmd_in.data; // [RQ13]
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cml_fault_out <= 1'b0;
    else if (wr_resp && bad_act)
      cml_fault_out <= 1'b1; // [RQ7]
    else if (clear_faults_in)
      cml_fault_out <= 1'b0;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rd_data_out  <= 16'h0000;
      rd_valid_out <= 1'b0;
    end
    else
    begin
      rd_valid_out <= cmd_in.rd;
      case (cmd_in.code)
        `TFRC_CMD_OT_RESP:  rd_data_out <= {8'h00, ot_resp};
        `TFRC_CMD_UT_RESP:  rd_data_out <= {8'h00, ut_resp};
        `TFRC_CMD_PIN_MASK: rd_data_out <= pin_mask;
        default:            rd_data_out <= 16'h0000;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // fault levels arrive already qualified by the ADC scan, so the 80 ms
  // budget is spent upstream; here the response follows in one cycle [RQ5]
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ot_q <= 1'b0;
      ut_q <= 1'b0;
      // idles at the commanded-on level so release of reset is no false off-on edge
      on_q <= 1'b1;
    end
    else
    begin
      ot_q <= fault_in.ot;
      ut_q <= fault_in.ut;
      on_q <= on_cmd_in;
    end
  end

  assign ot_event     = fault_in.ot && !ot_q;
  assign ut_event     = fault_in.ut && !ut_q;
  assign off_on_clear = on_cmd_in && !on_q;

  // set wins over every clear [RQ9]
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ot_status_out <= 1'b0;
      ut_status_out <= 1'b0;
    end
    else
    begin
      if (ot_event)
        ot_status_out <= 1'b1; // [RQ3]
      else if (clear_faults_in || off_on_clear)
        ot_status_out <= 1'b0; // [RQ9]
      if (ut_event)
        ut_status_out <= 1'b1; // [RQ4]
      else if (clear_faults_in || off_on_clear)
        ut_status_out <= 1'b0; // [RQ9]
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      temp_summary_out <= 1'b0;
      alert_b_out      <= 1'b1;
    end
    else
    begin
      // alert stays even for response 00 [RQ6]
      if (ot_event || ut_event)
      begin
        temp_summary_out <= 1'b1; // [RQ3] [RQ4]
        alert_b_out      <= 1'b0; // [RQ3] [RQ4]
      end
      else if (clear_faults_in || off_on_clear)
      begin
        temp_summary_out <= 1'b0;
        alert_b_out      <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  assign ot_shut  = fault_in.ot && ot_resp[`TFRC_RESP_HI:`TFRC_RESP_LO] == `TFRC_ACT_SHUTDOWN; // [RQ8]
  assign ut_shut  = fault_in.ut && ut_resp[`TFRC_RESP_HI:`TFRC_RESP_LO] == `TFRC_ACT_SHUTDOWN; // [RQ8]
  assign any_shut = ot_shut || ut_shut;
  // both faults must allow retry; any never-retry cause wins [RQ11]
  assign forever_retry = (!ot_shut || ot_resp[`TFRC_RETRY_HI:`TFRC_RETRY_LO] == `TFRC_RETRY_FOREVER)
                      && (!ut_shut || ut_resp[`TFRC_RETRY_HI:`TFRC_RETRY_LO] == `TFRC_RETRY_FOREVER);

  always_comb
  begin
    next_state = state;
    case (state)
      tfrc_pkg::TFRC_RUN:
        if (any_shut)
          next_state = forever_retry ? tfrc_pkg::TFRC_OFF_WAIT : tfrc_pkg::TFRC_OFF_HOLD; // [RQ8]
      tfrc_pkg::TFRC_OFF_HOLD:
        if (clear_faults_in || !on_cmd_in)
          next_state = tfrc_pkg::TFRC_RUN; // [RQ10]
      tfrc_pkg::TFRC_OFF_WAIT:
        if (!on_cmd_in)
          next_state = tfrc_pkg::TFRC_RUN;
        else if (any_shut && !forever_retry)
          next_state = tfrc_pkg::TFRC_OFF_HOLD;
        else if (retry_done)
          next_state = tfrc_pkg::TFRC_RUN; // [RQ11]
      default:
        next_state = tfrc_pkg::TFRC_RUN;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      state <= tfrc_pkg::TFRC_RUN;
    else
      state <= next_state;
  end

  assign retry_start = state != tfrc_pkg::TFRC_OFF_WAIT;

  tfrc_retry_timer #(
    .CYCLES (RETRY_CYCLES)
  ) u_retry (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .start_in (retry_start),
    .run_in   (state == tfrc_pkg::TFRC_OFF_WAIT),
    .done_out (retry_done)
  );

  // output drops in the same edge as the shutdown decision [RQ8] [RQ6]
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      output_en_out <= 1'b0;
    else
      output_en_out <= on_cmd_in && next_state == tfrc_pkg::TFRC_RUN && !(state == tfrc_pkg::TFRC_RUN && any_shut);
  end
  ////////////////////////////////////////////////////////////////////////
  // pin follows fault levels only for faults that act [RQ14]
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      gpio_b_out <= 1'b1;
    else
      gpio_b_out <= !((ot_shut && pin_mask[`TFRC_MASK_OT_BIT])    // [RQ15]
                   || (ut_shut && pin_mask[`TFRC_MASK_UT_BIT]));  // [RQ16]
  end
  ////////////////////////////////////////////////////////////////////////
  AST_RESET_VALUE: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ1]
    $rose(rst_b_in) |-> ot_resp == `TFRC_RESP_RESET) else $error("ot response reset wrong");
  AST_BAD_WRITE: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ7]
    wr_resp && bad_act |=> cml_fault_out && $stable(ot_resp) && $stable(ut_resp))
    else $error("bad response write not flagged");
  AST_OT_FLAG: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ3]
    ot_event |=> ot_status_out && temp_summary_out && !alert_b_out) else $error("ot flags missing");
  AST_UT_FLAG: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ4]
    ut_event |=> ut_status_out && temp_summary_out && !alert_b_out) else $error("ut flags missing");
  AST_HOLD_LATCH: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ9]
    ot_status_out && !clear_faults_in && !off_on_clear |=> ot_status_out) else $error("ot bit lost");
  AST_SHUTDOWN: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ8]
    state == tfrc_pkg::TFRC_RUN && any_shut |=> !output_en_out) else $error("no shutdown");
  AST_NO_RESTART: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ10]
    state == tfrc_pkg::TFRC_OFF_HOLD && !clear_faults_in && on_cmd_in |=> !output_en_out)
    else $error("restart without retry");
  AST_CONTINUE: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ6]
    state == tfrc_pkg::TFRC_RUN && on_cmd_in && !any_shut && $past(on_cmd_in) |=> output_en_out)
    else $error("output dropped with no response");
  AST_PIN_GATE: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ14]
    !any_shut |=> gpio_b_out) else $error("ignored fault reached pin");
endmodule // tfrc_ctrl
`default_nettype wire

// File: inc/tfrc_consts.svh
`ifndef TFRC_CONSTS_SVH
`define TFRC_CONSTS_SVH
`define TFRC_CMD_OT_RESP      8'h50
`define TFRC_CMD_UT_RESP      8'h54
`define TFRC_CMD_PIN_MASK     8'hD2
`define TFRC_RESP_RESET       8'hB8
`define TFRC_MASK_RESET       16'h2993
`define TFRC_RESP_HI          7
`define TFRC_RESP_LO          6
`define TFRC_RETRY_HI         5
`define TFRC_RETRY_LO         3
`define TFRC_ACT_CONTINUE     2'h0
`define TFRC_ACT_SHUTDOWN     2'h2
`define TFRC_RETRY_NEVER      3'h0
`define TFRC_RETRY_FOREVER    3'h7
`define TFRC_MASK_OT_BIT      7
`define TFRC_MASK_UT_BIT      8
`define TFRC_CLK_MHZ          200
`define TFRC_RESP_TIME_MS     80
`define TFRC_RESP_CYCLES      (`TFRC_RESP_TIME_MS * `TFRC_CLK_MHZ * 1000)
`define TFRC_RETRY_CYCLES     1000
`endif

// File: inc/tfrc_pkg.sv
`default_nettype none
package tfrc_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] code;
    logic [15:0] data;
  } tfrc_cmd_t;

  typedef struct packed {
    logic ot;
    logic ut;
  } tfrc_fault_t;

  typedef enum logic [1:0] {TFRC_RUN, TFRC_OFF_HOLD, TFRC_OFF_WAIT} tfrc_state_t;
endpackage
`default_nettype wire

// File: hdl/tfrc_retry_timer.sv
`default_nettype none
`include "tfrc_consts.svh"
module tfrc_retry_timer #(
  parameter int unsigned CYCLES = `TFRC_RETRY_CYCLES
) (
  input  wire logic clk_in,     // device clock
  input  wire logic rst_b_in,   // async reset, active low
  input  wire logic start_in,   // restart counting
  input  wire logic run_in,     // count while high
  output logic      done_out    // one-cycle pulse at expiry
);
  logic [31:0] count;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      count    <= 32'h0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      if (start_in || !run_in)
        count <= 32'h0;
      else if (count >= CYCLES - 1)
      begin
        count    <= 32'h0;
        done_out <= 1'b1;
      end
      else
        count <= count + 32'h1;
    end
  end
endmodule // tfrc_retry_timer
`default_nettype wire

// File: verification/tfrc_host_model.sv
`default_nettype none
module tfrc_host_model
(
  input  wire logic                 clk_in,      // device clock
  output var  tfrc_pkg::tfrc_cmd_t  cmd_out      // decoded command toward the device
);
  timeunit 1ns;
  timeprecision 1ps;

  initial cmd_out = '0;

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle command pulse; between commands the code and data lines show the
  // inverse of the last word, so stale values are never mistaken for a command
  task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(negedge clk_in);
    cmd_out <= {w, ~w, c, d};
    @(negedge clk_in);
    cmd_out <= {2'b00, ~c, ~d};
  endtask
endmodule // tfrc_host_model
`default_nettype wire

// File: verification/tfrc_ctrl_test.sv
`default_nettype none
`include "tfrc_consts.svh"
module tfrc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned RETRY = 10;
  logic                  clk_in = 1'b0;
  logic                  rst_b_in = 1'b0;
  tfrc_pkg::tfrc_cmd_t   cmd;
  tfrc_pkg::tfrc_fault_t fault = '0;
  logic                  clr = 1'b0;
  logic                  on_cmd = 1'b1;
  logic [15:0]           rd_data;
  logic                  rd_valid, cml, summ, ot_st, ut_st, alert_b, gpio_b, out_en;
  logic [5:0]            seen;
  logic [15:0]           val;
  logic [7:0]            rb;
  int                    miscompares = 0;
  int                    n_compared = 0;

  assign seen = {summ, ot_st, ut_st, alert_b, gpio_b, out_en};
  always #2.5 clk_in = ~clk_in;

  tfrc_host_model host (.clk_in(clk_in), .cmd_out(cmd));

  tfrc_ctrl #(.RETRY_CYCLES(RETRY)) dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .cmd_in(cmd), .fault_in(fault),
    .clear_faults_in(clr), .on_cmd_in(on_cmd), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .cml_fault_out(cml), .temp_summary_out(summ),
    .ot_status_out(ot_st), .ut_status_out(ut_st), .alert_b_out(alert_b),
    .gpio_b_out(gpio_b), .output_en_out(out_en));

  ////////////////////////////////////////////////////////////////////////////
  // expected flag vector: summary, ot, ut, alert_b, gpio_b, enable
  function automatic logic [5:0] flags(input logic ot, input logic ut, input logic pin, input logic en);
    return {ot | ut, ot, ut, ~(ot | ut), ~pin, en};
  endfunction

  // a refused write leaves the stored byte as it was
  function automatic logic [7:0] stored(input logic [7:0] old, input logic [7:0] nw);
    return nw[6] ? old : nw;
  endfunction

  task automatic close_out();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flags(input logic [5:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t flags %b expected %b", $time, seen, exp);
    end
  endtask

  // answer stands one cycle, so it is looked at in the cycle after the read edge
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
    host.send(1'b0, c, 16'h0000);
    chk_word({15'h0000, rd_valid}, 16'h0001);
    chk_word(rd_data, exp);
  endtask

  task automatic wait_en(input logic v, input int n);
    n_compared++;
    for (int i = 0; i < n; i++)
    begin
      if (out_en === v)
        return;
      @(negedge clk_in);
    end
    miscompares++;
    $display("[ERR] %0t enable did not reach %b", $time, v);
    close_out();
  endtask

  task automatic settle();
    repeat (2) @(negedge clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(30));
    repeat (5) @(negedge clk_in);
    rst_b_in = 1'b1;
    rd_chk(`TFRC_CMD_OT_RESP, 16'h00B8);
    rd_chk(`TFRC_CMD_UT_RESP, 16'h00B8);
    rd_chk(`TFRC_CMD_PIN_MASK, 16'h2993);
    wait_en(1'b1, 20);
    for (int i = 0; i < 8; i++)
    begin
      rb = 8'($urandom) & 8'hBF;
      host.send(1'b1, `TFRC_CMD_OT_RESP, {8'h00, rb});
      rd_chk(`TFRC_CMD_OT_RESP, {8'h00, rb});
      val = 16'($urandom);
      host.send(1'b1, `TFRC_CMD_PIN_MASK, val);
      rd_chk(`TFRC_CMD_PIN_MASK, val);
    end
    // both unsupported response codes: refused and flagged
    for (int k = 0; k < 2; k++)
    begin
      rb = (k != 0) ? 8'hC0 : 8'h47;
      host.send(1'b1, `TFRC_CMD_UT_RESP, {8'h00, rb});
      @(negedge clk_in);
      chk_word({15'h0000, cml}, 16'h0001);
      rd_chk(`TFRC_CMD_UT_RESP, {8'h00, stored(8'hB8, rb)});
      clr = 1'b1;
      @(negedge clk_in);
      clr = 1'b0;
    end
    // continue-running response: flags and alert only
    host.send(1'b1, `TFRC_CMD_OT_RESP, 16'h0038);
    host.send(1'b1, `TFRC_CMD_PIN_MASK, 16'h0180);
    fault.ot = 1'b1;
    settle();
    chk_flags(flags(1'b1, 1'b0, 1'b0, 1'b1));
    fault.ot = 1'b0;
    settle();
    chk_flags(flags(1'b1, 1'b0, 1'b0, 1'b1));
    clr = 1'b1;
    @(negedge clk_in);
    clr = 1'b0;
    settle();
    chk_flags(flags(1'b0, 1'b0, 1'b0, 1'b1));
    // shutdown with no retry; the delay field must not postpone it
    host.send(1'b1, `TFRC_CMD_UT_RESP, 16'h0087);
    host.send(1'b1, `TFRC_CMD_PIN_MASK, 16'h0100);
    fault.ut = 1'b1;
    settle();
    chk_flags(flags(1'b0, 1'b1, 1'b1, 1'b0));
    fault.ut = 1'b0;
    repeat (3 * RETRY) @(negedge clk_in);
    chk_flags(flags(1'b0, 1'b1, 1'b0, 1'b0));
    on_cmd = 1'b0;
    settle();
    on_cmd = 1'b1;
    settle();
    chk_flags(flags(1'b0, 1'b0, 1'b0, 1'b1));
    wait_en(1'b1, 3 * RETRY);
    // default response: shutdown, then endless retry
    host.send(1'b1, `TFRC_CMD_OT_RESP, 16'h00B8);
    host.send(1'b1, `TFRC_CMD_PIN_MASK, 16'h0080);
    fault.ot = 1'b1;
    settle();
    chk_flags(flags(1'b1, 1'b0, 1'b1, 1'b0));
    fault.ot = 1'b0;
    wait_en(1'b1, 4 * RETRY);
    chk_flags(flags(1'b1, 1'b0, 1'b0, 1'b1));
    close_out();
  end
endmodule // tfrc_ctrl_test
`default_nettype wire
